// File: include/vsc_pkg.sv
// vsc_pkg: constants and types of the serial command unit of a display controller.
// assumes a single 100 MHz clock; all serial pins arrive asynchronously.
`default_nettype none
package vsc_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and scan timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_STEP_NS = 2000;
  localparam int SCAN_STEP_CYCLES = SCAN_STEP_NS / CLK_PERIOD_NS;
  localparam logic [7:0] STEP_DIV_LAST = 8'(SCAN_STEP_CYCLES - 1);
  localparam logic [3:0] FRAME_LAST_STEP = 4'hF;
  ////////////////////////////////////////////////////////////////////////////////
  // pin bundle order {serial_in, shift_clock, frame_strobe} and its idle level
  localparam int PIN_STB = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 2;
  localparam logic [2:0] PIN_IDLE = 3'h3;
  ////////////////////////////////////////////////////////////////////////////////
  // command byte classes in b7..b6
  localparam logic [1:0] CLASS_MODE = 2'h0;
  localparam logic [1:0] CLASS_DATA = 2'h1;
  localparam logic [1:0] CLASS_CTRL = 2'h2;
  localparam logic [1:0] CLASS_ADDR = 2'h3;
  // data setting fields
  localparam logic [1:0] DS_TGT_DISP = 2'h0;
  localparam logic [1:0] DS_TGT_LED = 2'h1;
  localparam logic [1:0] DS_TGT_KEY = 2'h2;
  localparam logic [1:0] DS_TGT_SW = 2'h3;
  localparam int DS_FIXED_BIT = 2;
  localparam logic [3:0] DS_RESET = 4'h0;
  // display control fields
  localparam int CTRL_ON_BIT = 3;
  localparam logic [2:0] PW_RESET = 3'h0;
  // display mode field
  localparam logic [3:0] MODE_RESET = 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // memories and ports
  localparam int DISP_RAM_BYTES = 48;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam logic [5:0] ADDR_LAST = 6'h2F;
  localparam int LED_COUNT = 5;
  localparam logic [4:0] LED_RESET = 5'h1F;
  localparam int SW_COUNT = 4;
  localparam int KEY_SOURCES = 12;
  localparam int KEY_RETURNS = 4;
  localparam int KEY_BITS = 48;
  localparam logic [5:0] KEY_BIT_LAST = 6'h2F;
  localparam logic [5:0] SW_BIT_LAST = 6'h07;
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_BODY} vsc_phase_type;
  typedef enum logic [1:0] {TGT_DISP, TGT_LED, TGT_KEY, TGT_SW} vsc_target_type;
endpackage : vsc_pkg
`default_nettype wire

// File: src/vsc_key_scan.sv
// vsc_key_scan: key matrix scanner, twelve sources by four returns, two frames a cycle.
// assumes scan_en comes from logic on the same clock; return inputs are raw pins.
`default_nettype none
module vsc_key_scan
  import vsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scan_en,
  input wire logic [KEY_RETURNS-1:0] key_return_inputs,
  output logic [KEY_SOURCES-1:0] key_source_lines,
  output logic [KEY_BITS-1:0] key_data
);
  logic [KEY_RETURNS-1:0] ret_s1_ff, ret_s2_ff, ret_s3_ff, ret_ff;
  logic [7:0] div_ff;
  logic [3:0] step_ff;
  logic frame_ff;
  logic step_tick;
  logic [KEY_SOURCES-1:0] src_ff;
  logic [KEY_BITS-1:0] work_ff;
  logic [KEY_BITS-1:0] key_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // return inputs: a level counts once the last two stages agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ret_s1_ff <= '0;
      ret_s2_ff <= '0;
      ret_s3_ff <= '0;
      ret_ff <= '0;
    end
    else
    begin
      ret_s1_ff <= key_return_inputs;
      ret_s2_ff <= ret_s1_ff;
      ret_s3_ff <= ret_s2_ff;
      ret_ff <= (ret_s2_ff & ret_s3_ff) | (ret_ff & (ret_s2_ff ^ ret_s3_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // step divider, step and frame counters; halted scanning restarts from step 0
  assign step_tick = (div_ff == STEP_DIV_LAST);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff <= '0;
      step_ff <= '0;
      frame_ff <= 1'b0;
    end
    else if (!scan_en)
    begin
      div_ff <= '0;
      step_ff <= '0;
      frame_ff <= 1'b0;
    end
    else
    begin
      div_ff <= step_tick ? 8'h00 : div_ff + 8'h01;
      if (step_tick)
      begin
        step_ff <= step_ff + 4'h1;
        if (step_ff == FRAME_LAST_STEP)
          frame_ff <= ~frame_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one source high in each of steps 0-11 of the first frame; returns sampled at the step's end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      src_ff <= '0;
    else if (scan_en && !frame_ff && step_ff < 4'(KEY_SOURCES))
      src_ff <= 12'h001 << step_ff; // R4
    else
      src_ff <= '0;
  end

  // source s fills bits 4s..4s+3, so even index sits low and odd index high in a byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      work_ff <= '0;
    else if (scan_en && step_tick && !frame_ff && step_ff < 4'(KEY_SOURCES))
      work_ff[step_ff*KEY_RETURNS +: KEY_RETURNS] <= ret_ff; // R5
  end

  // the host only ever sees a complete matrix: copied once at the end of frame two
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      key_ff <= '0;
    else if (scan_en && step_tick && frame_ff && step_ff == FRAME_LAST_STEP)
      key_ff <= work_ff; // R14
  end

  assign key_source_lines = src_ff;
  assign key_data = key_ff;
endmodule : vsc_key_scan
`default_nettype wire

// File: src/vsc_command_unit.sv
// vsc_command_unit: three-wire serial command interpreter with display memory,
// indicator port, switch read and key read; instantiates the key scanner.
// assumes the host keeps the strobe high between frames and the wait before reads.
// Function
// R1 - b7=0,b6=1 is data setting; b5,b4 ignored
// R2 - data setting picks write or read
// R3 - data setting low nibble resets to zero
// R4 - scan twelve sources by four returns
// R5 - odd source low nibble, even source high
// R6 - key read LSB first, bytes run on
// R7 - indicator port bits 0-4 map outputs 1-5
// R8 - port bit 0 lights, 1 darkens
// R9 - indicator port bits reset to one
// R10 - switch read: four inputs, upper nibble zero
// R11 - addresses 00-2F valid, else discard
// R12 - address pointer resets to zero
// R13 - control sets on/off, width; reset off
// R14 - key cycle spans two frames, then stored
// R15 - host waits 1 us before reading
// R16 - address advances after each byte stored
// R17 - host bulk refresh command sequence
// R18 - host single location update sequence
// R19 - first byte after strobe fall is command
// R20 - strobe rise aborts partial byte
// R21 - in on rising, out on falling, LSB first
// R22 - data setting selects target and addressing
// R23 - control: on bit, 3-bit width field
`default_nettype none
module vsc_command_unit
  import vsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frame_strobe,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic [SW_COUNT-1:0] general_inputs,
  input wire logic [KEY_RETURNS-1:0] key_return_inputs,
  output logic [KEY_SOURCES-1:0] key_source_lines,
  output logic [LED_COUNT-1:0] indicator_outputs_n,
  output logic display_on,
  output logic [2:0] pulse_width,
  output logic [3:0] display_mode,
  input wire logic [5:0] disp_rd_addr,
  output logic [7:0] disp_rd_data
);
  logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff, pin_prev_ff;
  logic [SW_COUNT-1:0] sw_s1_ff, sw_s2_ff, sw_s3_ff, sw_ff;
  logic stb_low, stb_fall, stb_rise, sclk_rise, sclk_fall;
  vsc_phase_type phase_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic byte_done, cmd_done, body_done;
  logic [7:0] rx_byte;
  logic [3:0] ds_ff;
  logic body_wr_ff;
  logic reading_ff;
  logic [5:0] rd_idx_ff;
  logic [7:0] sw_snap_ff;
  logic [5:0] addr_ff;
  logic [7:0] ram_ff [DISP_RAM_BYTES];
  logic [LED_COUNT-1:0] led_ff;
  logic disp_on_ff;
  logic [2:0] pw_ff;
  logic [3:0] mode_ff;
  logic serial_out_ff, serial_out_oe_ff;
  logic [7:0] disp_rd_data_ff;
  logic [KEY_BITS-1:0] key_data;
  logic rd_bit;
  logic addr_valid;

  // the data setting target is needed both per body byte written and per read bit
  function automatic vsc_target_type decode_target(input logic [1:0] code);
    vsc_target_type t;
    t = TGT_DISP;
    unique case (code)
      DS_TGT_DISP: t = TGT_DISP;
      DS_TGT_LED: t = TGT_LED;
      DS_TGT_KEY: t = TGT_KEY;
      DS_TGT_SW: t = TGT_SW;
    endcase
    return t; // R22
  endfunction : decode_target

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_ff <= PIN_IDLE;
      pin_s2_ff <= PIN_IDLE;
      pin_s3_ff <= PIN_IDLE;
      pin_ff <= PIN_IDLE;
      pin_prev_ff <= PIN_IDLE;
    end
    else
    begin
      pin_s1_ff <= {serial_in, shift_clock, frame_strobe};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff ^ pin_s3_ff));
      pin_prev_ff <= pin_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_s1_ff <= '0;
      sw_s2_ff <= '0;
      sw_s3_ff <= '0;
      sw_ff <= '0;
    end
    else
    begin
      sw_s1_ff <= general_inputs;
      sw_s2_ff <= sw_s1_ff;
      sw_s3_ff <= sw_s2_ff;
      sw_ff <= (sw_s2_ff & sw_s3_ff) | (sw_ff & (sw_s2_ff ^ sw_s3_ff));
    end
  end

  assign stb_low = !pin_ff[PIN_STB];
  assign stb_fall = !pin_ff[PIN_STB] && pin_prev_ff[PIN_STB];
  assign stb_rise = pin_ff[PIN_STB] && !pin_prev_ff[PIN_STB];
  // shift clock edges only count inside a frame
  assign sclk_rise = stb_low && pin_ff[PIN_SCLK] && !pin_prev_ff[PIN_SCLK]; // R21
  assign sclk_fall = stb_low && !pin_ff[PIN_SCLK] && pin_prev_ff[PIN_SCLK]; // R21

  ////////////////////////////////////////////////////////////////////////////////
  // serial receiver
  assign rx_byte = {pin_ff[PIN_DIN], shift_ff[7:1]}; // R21
  assign byte_done = sclk_rise && !stb_fall && phase_ff != PH_IDLE && bit_cnt_ff == 3'h7;
  assign cmd_done = byte_done && phase_ff == PH_CMD;
  assign body_done = byte_done && phase_ff == PH_BODY;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= PH_IDLE;
    else if (stb_rise)
      phase_ff <= PH_IDLE; // R20
    else if (stb_fall)
      phase_ff <= PH_CMD; // R19
    else if (cmd_done)
      phase_ff <= PH_BODY; // R19
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff <= '0;
      bit_cnt_ff <= '0;
    end
    else if (stb_rise || stb_fall)
    begin
      shift_ff <= '0; // R20
      bit_cnt_ff <= '0; // R20
    end
    else if (sclk_rise && phase_ff != PH_IDLE)
    begin
      shift_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ds_ff <= DS_RESET; // R3
    else if (cmd_done && rx_byte[7:6] == CLASS_DATA)
      ds_ff <= rx_byte[3:0]; // R1
  end

  // a frame carries body writes after a write-type setting, or after an address command while one is in force
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      body_wr_ff <= 1'b0;
    else if (stb_fall)
      body_wr_ff <= 1'b0;
    else if (cmd_done)
    begin
      unique case (rx_byte[7:6])
        CLASS_DATA: body_wr_ff <= !rx_byte[1]; // R2
        CLASS_ADDR: body_wr_ff <= !ds_ff[1]; // R2
        CLASS_MODE, CLASS_CTRL: body_wr_ff <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disp_on_ff <= 1'b0; // R13
      pw_ff <= PW_RESET; // R13
      mode_ff <= MODE_RESET;
    end
    else if (cmd_done && rx_byte[7:6] == CLASS_CTRL)
    begin
      disp_on_ff <= rx_byte[CTRL_ON_BIT]; // R23
      pw_ff <= rx_byte[2:0]; // R23
    end
    else if (cmd_done && rx_byte[7:6] == CLASS_MODE && rx_byte[3:0] != mode_ff)
    begin
      // a new display mode blanks the display and halts scanning until turned on
      mode_ff <= rx_byte[3:0];
      disp_on_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display memory and indicator port writes
  assign addr_valid = (addr_ff <= ADDR_LAST); // R11

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      addr_ff <= ADDR_RESET; // R12
    else if (cmd_done && rx_byte[7:6] == CLASS_ADDR)
      addr_ff <= rx_byte[5:0];
    else if (body_done && body_wr_ff && decode_target(ds_ff[1:0]) == TGT_DISP
             && addr_valid && !ds_ff[DS_FIXED_BIT])
      addr_ff <= addr_ff + 6'h01; // R16
  end

  // no reset on the display memory: contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (body_done && body_wr_ff && decode_target(ds_ff[1:0]) == TGT_DISP && addr_valid)
      ram_ff[addr_ff] <= rx_byte; // R11
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      led_ff <= LED_RESET; // R9
    else if (body_done && body_wr_ff && decode_target(ds_ff[1:0]) == TGT_LED)
      led_ff <= rx_byte[LED_COUNT-1:0]; // R7
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      disp_rd_data_ff <= '0;
    else if (disp_rd_addr <= ADDR_LAST)
      disp_rd_data_ff <= ram_ff[disp_rd_addr];
    else
      disp_rd_data_ff <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: bits leave on falling shift clock edges after the command byte
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reading_ff <= 1'b0;
      sw_snap_ff <= '0;
    end
    else if (stb_rise || stb_fall)
      reading_ff <= 1'b0;
    else if (cmd_done && rx_byte[7:6] == CLASS_DATA)
    begin
      reading_ff <= rx_byte[1]; // R2
      // switches are frozen at the command so one byte is self-consistent
      sw_snap_ff <= {4'h0, sw_ff}; // R10
    end
  end

  always_comb
  begin
    if (decode_target(ds_ff[1:0]) == TGT_KEY)
      rd_bit = key_data[rd_idx_ff]; // R6
    else
      rd_bit = sw_snap_ff[rd_idx_ff[2:0]]; // R10
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rd_idx_ff <= '0;
    else if (cmd_done)
      rd_idx_ff <= '0;
    else if (sclk_fall && reading_ff)
    begin
      if (decode_target(ds_ff[1:0]) == TGT_KEY)
        rd_idx_ff <= (rd_idx_ff == KEY_BIT_LAST) ? 6'h00 : rd_idx_ff + 6'h01; // R6
      else
        rd_idx_ff <= (rd_idx_ff == SW_BIT_LAST) ? 6'h00 : rd_idx_ff + 6'h01; // R10
    end
  end

  // open drain: the pin is only ever pulled low, a one is the pin released
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_out_ff <= 1'b0;
      serial_out_oe_ff <= 1'b0;
    end
    else if (stb_rise || stb_fall || cmd_done)
      serial_out_oe_ff <= 1'b0;
    else if (sclk_fall && reading_ff)
      serial_out_oe_ff <= !rd_bit; // R21
  end

  ////////////////////////////////////////////////////////////////////////////////
  // key scanner, halted while the display is off
  vsc_key_scan u_key_scan (
    .clock(clock),
    .rst_n(rst_n),
    .scan_en(disp_on_ff), // R13
    .key_return_inputs(key_return_inputs),
    .key_source_lines(key_source_lines),
    .key_data(key_data)
  );

  assign serial_out = serial_out_ff;
  assign serial_out_oe = serial_out_oe_ff;
  assign indicator_outputs_n = led_ff; // R8
  assign display_on = disp_on_ff;
  assign pulse_width = pw_ff;
  assign display_mode = mode_ff;
  assign disp_rd_data = disp_rd_data_ff;
endmodule : vsc_command_unit
`default_nettype wire

// File: sim/vsc_chk.sv
// vsc_chk: port-level checks of the serial command unit.
// assumes it is bound into every instance of vsc_command_unit.
`default_nettype none
module vsc_chk
  import vsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frame_strobe,
  input wire logic shift_clock,
  input wire logic serial_out_oe,
  input wire logic [11:0] key_source_lines,
  input wire logic [4:0] indicator_outputs_n,
  input wire logic display_on,
  input wire logic [2:0] pulse_width,
  input wire logic [5:0] disp_rd_addr,
  input wire logic [7:0] disp_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  chk_reset_values: assert property (
    $rose(rst_n) |-> indicator_outputs_n == LED_RESET && !display_on && pulse_width == PW_RESET)
    else $error("outputs not at reset values");
  chk_oe_idle: assert property (frame_strobe [*8] |-> !serial_out_oe)
    else $error("data out driven outside a frame");
  chk_hold_idle: assert property (
    frame_strobe [*8] |=> $stable(indicator_outputs_n) && $stable(display_on)
      && $stable(pulse_width))
    else $error("state changed while strobe high");
  chk_oe_on_fall: assert property ($rose(serial_out_oe) |-> !$past(shift_clock, 3))
    else $error("data out changed away from a falling clock");
  chk_oe_hold_high: assert property (
    (shift_clock && !frame_strobe) [*6] |-> $stable(serial_out_oe))
    else $error("data out changed while shift clock high");
  chk_src_onehot: assert property ($onehot0(key_source_lines))
    else $error("more than one key source driven");
  // a mode change may halt the scan part way through a step
  chk_src_step: assert property (
    $changed(key_source_lines) |=> ($stable(key_source_lines) || !display_on) [*8])
    else $error("key source step too short");
  // the sources clear one cycle after the display goes off
  chk_scan_halt: assert property (!display_on [*3] |-> $stable(key_source_lines))
    else $error("key scan runs with display off");
  chk_rd_zero: assert property (disp_rd_addr > ADDR_LAST |=> disp_rd_data == 8'h00)
    else $error("out-of-range display address read nonzero");
  cover property ($rose(serial_out_oe));
  cover property ($rose(display_on));
  cover property ($changed(indicator_outputs_n));
endmodule : vsc_chk
bind vsc_command_unit vsc_chk i_vsc_chk (
  .clock(clock), .rst_n(rst_n), .frame_strobe(frame_strobe), .shift_clock(shift_clock),
  .serial_out_oe(serial_out_oe), .key_source_lines(key_source_lines),
  .indicator_outputs_n(indicator_outputs_n), .display_on(display_on),
  .pulse_width(pulse_width), .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data));
`default_nettype wire

// File: sim/vsc_host.sv
// vsc_host: host side of the three-wire link, worked through its tasks.
// assumes a pull-up on data out; 125 ns shift clock, free of the system clock.
`default_nettype none
module vsc_host
(
  output logic frame_strobe,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic dio;
  // the pull-up wins unless the device pulls low
  assign dio = serial_out_oe ? 1'b0 : 1'b1;
  initial
  begin
    frame_strobe = 1'b1;
    shift_clock = 1'b1;
    serial_in = 1'b1;
  end
  task automatic open_frame();
    frame_strobe = 1'b0;
    #125;
  endtask : open_frame
  task automatic close_frame();
    #190;
    frame_strobe = 1'b1;
    // data line no longer meaningful, so it is not left at the last bit
    serial_in = ~serial_in;
    #500;
  endtask : close_frame
  // n bits, LSB first; clock stands high between bits and between frames
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      shift_clock = 1'b0;
      serial_in = tx[i];
      #62.5;
      shift_clock = 1'b1;
      rx[i] = dio;
      #62.5;
    end
  endtask : xfer
endmodule : vsc_host
`default_nettype wire

// File: sim/testbench.sv
// testbench: self-checking bench of the serial command unit.
// assumes the host model owns the link pins; the bench drives the rest.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, frame_strobe, shift_clock, serial_in, serial_out, serial_out_oe;
  logic display_on;
  logic [3:0] general_inputs, key_return_inputs, display_mode;
  logic [11:0] key_source_lines;
  logic [4:0] indicator_outputs_n;
  logic [2:0] pulse_width;
  logic [5:0] disp_rd_addr;
  logic [7:0] disp_rd_data, rx;
  int mismatches, n_tests, cycles;
  vsc_command_unit i_vsc_command_unit (
    .clock(clock), .rst_n(rst_n), .frame_strobe(frame_strobe), .shift_clock(shift_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .general_inputs(general_inputs), .key_return_inputs(key_return_inputs),
    .key_source_lines(key_source_lines), .indicator_outputs_n(indicator_outputs_n),
    .display_on(display_on), .pulse_width(pulse_width), .display_mode(display_mode),
    .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data));
  vsc_host i_vsc_host (
    .frame_strobe(frame_strobe), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out_oe(serial_out_oe));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // key n+1 of each source s answers with the pattern s+1
  always @(posedge clock)
  begin
    key_return_inputs <= 4'h0;
    for (int s = 0; s < 12; s++)
      if (key_source_lines[s])
        key_return_inputs <= 4'(s + 1);
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    i_vsc_host.open_frame();
    i_vsc_host.xfer(c, 8, rx);
    for (int i = 0; i < n; i++)
      i_vsc_host.xfer(d[8*i+:8], 8, rx);
    i_vsc_host.close_frame();
  endtask : wr
  task automatic rd_start(input logic [7:0] c);
    i_vsc_host.open_frame();
    i_vsc_host.xfer(c, 8, rx);
    #1000;
  endtask : rd_start
  task automatic peek(input logic [5:0] a);
    @(posedge clock);
    disp_rd_addr <= a;
    repeat (2) @(posedge clock);
    #1;
  endtask : peek
  ////////////////////////////////////////
  task automatic t_disp();
    wr(8'hC0, 2, 16'h3CA5);
    wr(8'h44, 0, 16'h0000);
    wr(8'hC0, 2, 16'h2211);
    peek(6'h00);
    check("ram0", 8'h22, disp_rd_data);
    peek(6'h01);
    check("ram1", 8'h3C, disp_rd_data);
  endtask : t_disp
  task automatic t_range();
    wr(8'h40, 0, 16'h0000);
    wr(8'hEF, 2, 16'h6655);
    wr(8'hF0, 1, 16'h0099);
    peek(6'h2F);
    check("ram2f", 8'h55, disp_rd_data);
    peek(6'h00);
    check("ram0", 8'h22, disp_rd_data);
    peek(6'h30);
    check("ram30", 8'h00, disp_rd_data);
    // one location updated by an address command and a single byte
    wr(8'hC5, 1, 16'h0033);
    peek(6'h05);
    check("ram5", 8'h33, disp_rd_data);
  endtask : t_range
  task automatic t_led();
    wr(8'h41, 1, 16'h00EA);
    check("leds", 8'h0A, 8'(indicator_outputs_n));
    wr(8'h71, 1, 16'h0015);
    check("leds", 8'h15, 8'(indicator_outputs_n));
    // strobe rises half way through a byte that would light all five outputs
    i_vsc_host.open_frame();
    i_vsc_host.xfer(8'h41, 8, rx);
    i_vsc_host.xfer(8'h00, 4, rx);
    i_vsc_host.close_frame();
    check("leds", 8'h15, 8'(indicator_outputs_n));
  endtask : t_led
  task automatic t_sw();
    @(posedge clock);
    general_inputs <= 4'hA;
    rd_start(8'h43);
    for (int i = 0; i < 2; i++)
    begin
      i_vsc_host.xfer(8'hFF, 8, rx);
      check("switch", 8'h0A, rx);
    end
    i_vsc_host.close_frame();
  endtask : t_sw
  task automatic t_key();
    // bulk refresh order: setting, address with data, same mode, control
    wr(8'h40, 0, 16'h0000);
    wr(8'hC2, 2, 16'h7766);
    wr(8'h00, 0, 16'h0000);
    wr(8'h8D, 0, 16'h0000);
    peek(6'h03);
    check("ram3", 8'h77, disp_rd_data);
    check("mode", 8'h00, 8'(display_mode));
    check("disp_on", 8'h01, 8'(display_on));
    check("width", 8'h05, 8'(pulse_width));
    // a key cycle is two frames of 3200 cycles; wait for two key cycles
    repeat (13000) @(posedge clock);
    rd_start(8'h42);
    for (int j = 0; j < 7; j++)
    begin
      i_vsc_host.xfer(8'hFF, 8, rx);
      check("key", 8'(((j % 6) * 2 + 2) * 16 + (j % 6) * 2 + 1), rx);
    end
    i_vsc_host.close_frame();
    // a different display mode blanks the display and halts the scan
    wr(8'h01, 0, 16'h0000);
    check("mode", 8'h01, 8'(display_mode));
    check("disp_on", 8'h00, 8'(display_on));
  endtask : t_key
  initial
  begin
    rst_n = 1'b0;
    general_inputs = 4'h0;
    disp_rd_addr = 6'h00;
    key_return_inputs = 4'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    check("leds", 8'h1F, 8'(indicator_outputs_n));
    check("disp_on", 8'h00, 8'(display_on));
    check("width", 8'h00, 8'(pulse_width));
    check("mode", 8'h00, 8'(display_mode));
    check("dout", 8'h00, 8'(serial_out));
    check("dout_oe", 8'h00, 8'(serial_out_oe));
    t_disp();
    t_range();
    t_led();
    t_sw();
    t_key();
    test_done();
  end
endmodule : testbench
`default_nettype wire
